//--- txcvd_defs.svh
// Bit positions, offsets, reset values and timing counts for the transmit configuration decoder.
`ifndef TXCVD_DEFS_SVH
`define TXCVD_DEFS_SVH

// ----------------------------------------------------------------------------
// Vector layout
// ----------------------------------------------------------------------------
`define TXCVD_VEC_W          80
`define TXCVD_ADDR_HI        79
`define TXCVD_ADDR_LO        32
`define TXCVD_MTU_SIZE_HI    30
`define TXCVD_MTU_SIZE_LO    16
`define TXCVD_MTU_EN_BIT     14
`define TXCVD_DIC_BIT        10
`define TXCVD_WAN_BIT        9
`define TXCVD_IFG_ADJ_BIT    8
`define TXCVD_PREAMBLE_BIT   7
`define TXCVD_FC_BIT         5
`define TXCVD_JUMBO_BIT      4
`define TXCVD_FCS_BIT        3
`define TXCVD_VLAN_BIT       2
`define TXCVD_ENABLE_BIT     1
`define TXCVD_RESET_BIT      0
`define TXCVD_RSVD_MASK      80'h0000_0000_0000_8000_B840

// ----------------------------------------------------------------------------
// Register offsets (byte addresses) and reset values
// ----------------------------------------------------------------------------
`define TXCVD_OFS_VEC0       6'h00
`define TXCVD_OFS_VEC1       6'h04
`define TXCVD_OFS_VEC2       6'h08
`define TXCVD_OFS_STATUS     6'h0C
`define TXCVD_VEC_RESET      80'h0000_0000_0000_0000_0001

// ----------------------------------------------------------------------------
// Frame length and gap figures
// ----------------------------------------------------------------------------
`define TXCVD_LEN_STD        15'h05EE
`define TXCVD_LEN_VLAN       15'h05F2
`define TXCVD_LEN_JUMBO      15'h7FFF
`define TXCVD_MIN_IFG        8'h0C

`endif

//--- txcvd_pkg.sv
// Types shared by the transmit configuration decoder.
package txcvd_pkg;

	typedef struct packed {
		logic [47:0] pause_src_addr;
		logic        mtu_en;
		logic [14:0] mtu_size;
		logic [14:0] frame_len_limit;
		logic        dic_en;
		logic        wan_mode;
		logic        ifg_adjust_en;
		logic [7:0]  ifg_len;
		logic        preserve_preamble;
		logic        flow_ctrl_en;
		logic        jumbo_en;
		logic        inband_fcs;
		logic        vlan_en;
		logic        tx_enable;
		logic        tx_reset;
	} txcvd_cfg_t;

	typedef enum logic [1:0] {
		TXCVD_RESP_OKAY   = 2'h0,
		TXCVD_RESP_SLVERR = 2'h2
	} txcvd_resp_t;

endpackage

//--- txcvd_top.sv
// Transmit configuration vector decoder with optional AXI4-Lite management registers.
//
// Behaviour
// - Vector input drives config only when the management registers are left out.
// - Changes apply at frame end; reset and flow-control bits apply at once.
// - Bits 79:32 are the source address of generated pause frames.
// - Pause source address does not touch ordinary client frames.
// - Least significant address byte is the first byte on the line.
// - Bit 14 set limits frames to the size in bits 30:16.
// - Bit 10 set shortens gaps by deficit idle counting, else stretches them.
// - Deficit idle count forced off for LAN with in-band FCS, or gap adjust.
// - Bit 9 set selects WAN mode with rate-matching idles.
// - Bit 8 set takes gap length from client input, else minimum gap.
// - Gap adjust is ignored whenever WAN mode is selected.
// - Bit 7 set keeps the client preamble, else standard preamble.
// - Bit 5 set turns a pause request into a pause frame send.
// - Bit 4 set permits frames beyond the standard legal maximum.
// - Bit 3 set: client supplies FCS; clear: device pads and appends FCS.
// - Bit 2 set permits VLAN-tagged frames.
// - Transmitter runs only while bit 1 is set.
// - Bit 0 set holds the transmitter in reset.
`timescale 1ns/10ps
`include "txcvd_defs.svh"
`default_nettype none

module txcvd_top
	import txcvd_pkg::*;
#(
	parameter bit USE_MGMT = 1'b0
) (
	input  wire logic                  sys_clk,
	input  wire logic                  rst,
	input  wire logic                  clk_en,
	input  wire logic [79:0]           cfg_vector,
	input  wire logic                  frame_active,
	input  wire logic                  pause_req,
	input  wire logic [7:0]            tx_ifg_delay,
	output var  txcvd_cfg_t            tx_cfg,
	output logic                       pause_send,
	input  wire logic [5:0]            s_axi_awaddr,
	input  wire logic                  s_axi_awvalid,
	output logic                       s_axi_awready,
	input  wire logic [31:0]           s_axi_wdata,
	input  wire logic [3:0]            s_axi_wstrb,
	input  wire logic                  s_axi_wvalid,
	output logic                       s_axi_wready,
	output logic [1:0]                 s_axi_bresp,
	output logic                       s_axi_bvalid,
	input  wire logic                  s_axi_bready,
	input  wire logic [5:0]            s_axi_araddr,
	input  wire logic                  s_axi_arvalid,
	output logic                       s_axi_arready,
	output logic [31:0]                s_axi_rdata,
	output logic [1:0]                 s_axi_rresp,
	output logic                       s_axi_rvalid,
	input  wire logic                  s_axi_rready
);

	// ------------------------------------------------------------------------
	// Word selection
	// ------------------------------------------------------------------------
	// Returns 0..3 for a mapped word, 4 for an unmapped address.
	function automatic logic [2:0] word_sel(input logic [5:0] addr);
		unique case (addr)
			`TXCVD_OFS_VEC0:   word_sel = 3'h0;
			`TXCVD_OFS_VEC1:   word_sel = 3'h1;
			`TXCVD_OFS_VEC2:   word_sel = 3'h2;
			`TXCVD_OFS_STATUS: word_sel = 3'h3;
			default:           word_sel = 3'h4;
		endcase
	endfunction

	// ------------------------------------------------------------------------
	// Vector source
	// ------------------------------------------------------------------------
	localparam logic [79:0] VEC_RESET = `TXCVD_VEC_RESET;

	wire  logic [79:0] mgmt_vec;
	logic [79:0] src_vec;
	logic [79:0] applied;
	logic        pause_req_d;
	txcvd_cfg_t  next_cfg;

	// The management words win when built in; the pin vector is then unused.
	assign src_vec = (USE_MGMT ? mgmt_vec : cfg_vector) & ~`TXCVD_RSVD_MASK;

	// The vector is taken straight into this domain without a synchroniser.
	// A client that drives it from another clock risks a torn update.
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			applied <= `TXCVD_VEC_RESET;
		end else if (clk_en) begin
			if (!frame_active) begin
				applied <= src_vec;
			end else begin
				applied[`TXCVD_RESET_BIT] <= src_vec[`TXCVD_RESET_BIT];
				applied[`TXCVD_FC_BIT]    <= src_vec[`TXCVD_FC_BIT];
			end
		end
	end

	// ------------------------------------------------------------------------
	// Decode
	// ------------------------------------------------------------------------
	always_comb begin
		next_cfg = '0;
		// Byte [7:0] of the field leaves first; no client frame reads it.
		next_cfg.pause_src_addr    = applied[`TXCVD_ADDR_HI:`TXCVD_ADDR_LO];
		next_cfg.mtu_en            = applied[`TXCVD_MTU_EN_BIT];
		next_cfg.mtu_size          = applied[`TXCVD_MTU_SIZE_HI:`TXCVD_MTU_SIZE_LO];
		next_cfg.wan_mode          = applied[`TXCVD_WAN_BIT];
		next_cfg.ifg_adjust_en     = applied[`TXCVD_IFG_ADJ_BIT] & ~applied[`TXCVD_WAN_BIT];
		next_cfg.dic_en            = applied[`TXCVD_DIC_BIT] & ~next_cfg.ifg_adjust_en
			& ~(~applied[`TXCVD_WAN_BIT] & applied[`TXCVD_FCS_BIT]);
		next_cfg.ifg_len           = next_cfg.ifg_adjust_en ? tx_ifg_delay : `TXCVD_MIN_IFG;
		next_cfg.preserve_preamble = applied[`TXCVD_PREAMBLE_BIT];
		next_cfg.flow_ctrl_en      = applied[`TXCVD_FC_BIT];
		next_cfg.jumbo_en          = applied[`TXCVD_JUMBO_BIT];
		next_cfg.inband_fcs        = applied[`TXCVD_FCS_BIT];
		next_cfg.vlan_en           = applied[`TXCVD_VLAN_BIT];
		next_cfg.tx_enable         = applied[`TXCVD_ENABLE_BIT] & ~applied[`TXCVD_RESET_BIT];
		next_cfg.tx_reset          = applied[`TXCVD_RESET_BIT];
		if (next_cfg.mtu_en) begin
			next_cfg.frame_len_limit = next_cfg.mtu_size;
		end else if (next_cfg.jumbo_en) begin
			next_cfg.frame_len_limit = `TXCVD_LEN_JUMBO;
		end else if (next_cfg.vlan_en) begin
			next_cfg.frame_len_limit = `TXCVD_LEN_VLAN;
		end else begin
			next_cfg.frame_len_limit = `TXCVD_LEN_STD;
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			tx_cfg <= '0;
		end else if (clk_en) begin
			tx_cfg <= next_cfg;
		end
	end

	// ------------------------------------------------------------------------
	// Pause request
	// ------------------------------------------------------------------------
	// One pulse per rising request; a held request does not repeat frames.
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			pause_req_d <= 1'b0;
			pause_send  <= 1'b0;
		end else if (clk_en) begin
			pause_req_d <= pause_req;
			pause_send  <= pause_req & ~pause_req_d & applied[`TXCVD_FC_BIT] & ~applied[`TXCVD_RESET_BIT];
		end
	end

	// ------------------------------------------------------------------------
	// AXI4-Lite write channel
	// ------------------------------------------------------------------------
	logic       wr_go;
	logic [2:0] wr_sel;

	// Address and data are taken together, so a lone channel simply waits.
	assign wr_go  = s_axi_awvalid & s_axi_wvalid & ~s_axi_awready & ~s_axi_bvalid;
	assign wr_sel = word_sel(s_axi_awaddr);

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= TXCVD_RESP_OKAY;
		end else if (clk_en) begin
			s_axi_awready <= wr_go;
			s_axi_wready  <= wr_go;
			if (wr_go) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (wr_sel > 3'h2) ? TXCVD_RESP_SLVERR : TXCVD_RESP_OKAY;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Only the sixteen defined bits of the top word are kept.
	generate
		for (genvar b = 0; b < 10; b++) begin : g_lane
			logic [7:0] lane;
			// Each byte lane has its own flop so no two processes share a variable.
			always_ff @(posedge sys_clk or posedge rst) begin
				if (rst) begin
					lane <= VEC_RESET[b*8 +: 8];
				end else if (clk_en && wr_go && wr_sel == 3'(b / 4) && s_axi_wstrb[b % 4]) begin
					lane <= s_axi_wdata[(b % 4)*8 +: 8];
				end
			end
			assign mgmt_vec[b*8 +: 8] = lane;
		end
	endgenerate

	// ------------------------------------------------------------------------
	// AXI4-Lite read channel
	// ------------------------------------------------------------------------
	logic        rd_go;
	logic [2:0]  rd_sel;
	logic [31:0] rd_word;

	assign rd_go  = s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;
	assign rd_sel = word_sel(s_axi_araddr);

	// Reads show the configuration in force, not what is still pending.
	always_comb begin
		rd_word = 32'h0000_0000;
		unique case (rd_sel)
			3'h0:    rd_word = applied[31:0];
			3'h1:    rd_word = applied[63:32];
			3'h2:    rd_word = {16'h0000, applied[79:64]};
			3'h3:    rd_word = {28'h000_0000, 1'(USE_MGMT), frame_active, tx_cfg.dic_en, tx_cfg.ifg_adjust_en};
			default: rd_word = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= TXCVD_RESP_OKAY;
		end else if (clk_en) begin
			s_axi_arready <= rd_go;
			if (rd_go) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= rd_word;
				s_axi_rresp  <= (rd_sel > 3'h3) ? TXCVD_RESP_SLVERR : TXCVD_RESP_OKAY;
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

endmodule

`default_nettype wire

//--- txcvd_asserts.sv
// Concurrent checks on the transmit configuration decoder ports.
`timescale 1ns/10ps
`default_nettype none
module txcvd_asserts
	import txcvd_pkg::*;
(
	input wire logic        sys_clk,
	input wire logic        rst,
	input wire logic        clk_en,
	input wire logic [79:0] cfg_vector,
	input wire logic        frame_active,
	input wire logic        pause_req,
	input wire txcvd_cfg_t  tx_cfg,
	input wire logic        pause_send
);
	logic [1:0] up;
	// Past values are only trusted once three enabled edges have passed since reset or a freeze.
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) up <= 2'h0;
		else if (!clk_en) up <= 2'h0;
		else if (up != 2'h3) up <= up + 2'h1;
	end
	wire ok = (up == 2'h3);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);
	sequence one_pulse;
		pause_send ##1 !pause_send;
	endsequence
	src_addr_a: assert property (ok && !$past(frame_active, 2) |-> tx_cfg.pause_src_addr == $past(cfg_vector[79:32], 2))
		else $error("pause source address mismatch");
	mtu_map_a: assert property (ok && !$past(frame_active, 2) |-> tx_cfg.mtu_en == $past(cfg_vector[14], 2)
		&& tx_cfg.mtu_size == $past(cfg_vector[30:16], 2)) else $error("mtu fields mismatch");
	len_limit_a: assert property (ok |-> tx_cfg.frame_len_limit == (tx_cfg.mtu_en ? tx_cfg.mtu_size :
		tx_cfg.jumbo_en ? 15'h7FFF : tx_cfg.vlan_en ? 15'h05F2 : 15'h05EE)) else $error("length limit wrong");
	dic_gate_a: assert property (ok && tx_cfg.dic_en |-> !tx_cfg.ifg_adjust_en
		&& !(!tx_cfg.wan_mode && tx_cfg.inband_fcs)) else $error("deficit idle count not gated");
	wan_gate_a: assert property (ok |-> !(tx_cfg.wan_mode && tx_cfg.ifg_adjust_en)
		&& (tx_cfg.ifg_adjust_en || tx_cfg.ifg_len == 8'h0C)) else $error("gap adjust not gated");
	hold_frame_a: assert property (ok && $past(frame_active, 2) |-> $stable(tx_cfg.pause_src_addr)
		&& $stable(tx_cfg.jumbo_en) && $stable(tx_cfg.vlan_en)) else $error("change applied mid frame");
	reset_now_a: assert property (ok |-> tx_cfg.tx_reset == $past(cfg_vector[0], 2))
		else $error("transmit reset late");
	enable_gate_a: assert property (ok && tx_cfg.tx_reset |-> !tx_cfg.tx_enable)
		else $error("enabled while in reset");
	pulse_cause_a: assert property (ok && pause_send |-> $past(pause_req) && !$past(pause_req, 2))
		else $error("pause pulse without request edge");
	pulse_shape_a: assert property (ok && clk_en && $rose(pause_send) |-> one_pulse)
		else $error("pause pulse too long");
endmodule
bind txcvd_top txcvd_asserts txcvd_asserts_inst (.sys_clk(sys_clk), .rst(rst), .clk_en(clk_en), .cfg_vector(cfg_vector),
	.frame_active(frame_active), .pause_req(pause_req), .tx_cfg(tx_cfg), .pause_send(pause_send));
`default_nettype wire

//--- txcvd_client.sv
// Client model that drives the configuration vector.
`timescale 1ns/10ps
`include "txcvd_defs.svh"
`default_nettype none
module txcvd_client (
	input  wire logic        sys_clk,
	input  wire logic [79:0] want_vec,
	output var  logic [79:0] cfg_vector
);
	// Registered on the transmit clock so no change lands near a sampling edge.
	always_ff @(posedge sys_clk) begin
		cfg_vector <= want_vec & ~`TXCVD_RSVD_MASK;
	end
endmodule
`default_nettype wire

//--- tx_config_vector_decode_test.sv
// Self-checking testbench for the transmit configuration decoder.
`timescale 1ns/10ps
`include "txcvd_defs.svh"
`default_nettype none
module tx_config_vector_decode_test;
	import txcvd_pkg::*;
	logic sys_clk = 1'b0, rst = 1'b1, clk_en = 1'b1, frame_active = 1'b0, pause_req = 1'b0, pause_send;
	logic [79:0] want_vec = 80'h1, v;
	wire logic [79:0] cfg_vector;
	logic [7:0] tx_ifg_delay = 8'h00, g;
	txcvd_cfg_t tx_cfg;
	logic [5:0] awaddr = 6'h00, araddr = 6'h00;
	logic [31:0] wdata = 32'h0, rdata, d;
	logic [3:0] wstrb = 4'hF, cnt;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp, r;
	logic [95:0] rnd;
	logic [79:0] corner [6] = '{80'hFFEEDDCCBBAA_0040_4002, 80'h708, 80'h508, 80'h403, 80'h14, 80'h4};
	logic [79:0] pv [3] = '{80'h22, 80'h2, 80'h23};
	int err_count = 0, checks = 0, n;
	always #2 sys_clk = ~sys_clk;
	txcvd_client txcvd_client_inst (.sys_clk(sys_clk), .want_vec(want_vec), .cfg_vector(cfg_vector));
	txcvd_top txcvd_top_inst (.sys_clk(sys_clk), .rst(rst), .clk_en(clk_en), .cfg_vector(cfg_vector),
		.frame_active(frame_active), .pause_req(pause_req), .tx_ifg_delay(tx_ifg_delay), .tx_cfg(tx_cfg),
		.pause_send(pause_send), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready));
	function automatic txcvd_cfg_t expect_cfg(input logic [79:0] x, input logic [7:0] gap);
		txcvd_cfg_t c;
		logic adj;
		adj = x[8] & ~x[9];
		c.pause_src_addr = x[79:32];
		c.mtu_en = x[14];
		c.mtu_size = x[30:16];
		c.frame_len_limit = x[14] ? x[30:16] : x[4] ? 15'h7FFF : x[2] ? 15'h05F2 : 15'h05EE;
		c.dic_en = x[10] & ~adj & ~(~x[9] & x[3]);
		c.wan_mode = x[9];
		c.ifg_adjust_en = adj;
		c.ifg_len = adj ? gap : 8'h0C;
		c.preserve_preamble = x[7];
		c.flow_ctrl_en = x[5];
		c.jumbo_en = x[4];
		c.inband_fcs = x[3];
		c.vlan_en = x[2];
		c.tx_enable = x[1] & ~x[0];
		c.tx_reset = x[0];
		return c;
	endfunction
	task automatic chk(input string nm, input logic [127:0] e, input logic [127:0] s);
		checks++;
		if (e !== s) begin
			err_count++;
			$display("Error %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic wrap_up();
		$display("Checks %0d errors %0d", checks, err_count);
		if (err_count == 0 && checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	// Each channel drops its valid at the edge where its ready is seen high.
	task automatic axi(input logic wr, input logic [5:0] a);
		int t;
		@(posedge sys_clk);
		if (wr) begin
			awaddr <= a;
			awvalid <= 1'b1;
			wvalid <= 1'b1;
			bready <= 1'b1;
		end else begin
			araddr <= a;
			arvalid <= 1'b1;
			rready <= 1'b1;
		end
		t = 0;
		do begin
			@(posedge sys_clk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			if (arready) arvalid <= 1'b0;
			t++;
		end while (!(wr ? bvalid : rvalid) && t < 50);
		if (t >= 50) err_count++;
		r = wr ? bresp : rresp;
		d = rdata;
		bready <= 1'b0;
		rready <= 1'b0;
	endtask
	initial begin
		#20000;
		err_count++;
		wrap_up();
	end
	initial begin
		n = $urandom(32'h4E862527);
		repeat (10) @(posedge sys_clk);
		rst <= 1'b0;
		for (int i = 0; i < 30; i++) begin
			rnd = {$urandom(), $urandom(), $urandom()};
			v = (i < 6) ? corner[i] : rnd[79:0];
			g = rnd[87:80];
			@(posedge sys_clk);
			want_vec <= v;
			tx_ifg_delay <= g;
			repeat (4) @(posedge sys_clk);
			#1 chk("tx_cfg", 128'(expect_cfg(v & ~`TXCVD_RSVD_MASK, g)), 128'(tx_cfg));
		end
		@(posedge sys_clk);
		want_vec <= 80'h22;
		repeat (4) @(posedge sys_clk);
		frame_active <= 1'b1;
		want_vec <= 80'h123456789ABC_0000_0015;
		repeat (4) @(posedge sys_clk);
		#1 chk("held cfg", 128'(expect_cfg(80'h3, g)), 128'(tx_cfg));
		axi(1'b0, 6'h0C);
		chk("status", 128'({r, d[3:2]}), 128'(4'h1));
		frame_active <= 1'b0;
		repeat (4) @(posedge sys_clk);
		#1 chk("applied cfg", 128'(expect_cfg(80'h123456789ABC_0000_0015, g)), 128'(tx_cfg));
		for (int j = 0; j < 3; j++) begin
			@(posedge sys_clk);
			want_vec <= pv[j];
			repeat (4) @(posedge sys_clk);
			cnt = 4'h0;
			for (int k = 0; k < 8; k++) begin
				pause_req <= (k < 3);
				@(posedge sys_clk);
				cnt = cnt + pause_send;
			end
			chk("pause count", 128'(cnt), 128'(j == 0));
		end
		@(posedge sys_clk);
		clk_en <= 1'b0;
		want_vec <= 80'h6;
		repeat (4) @(posedge sys_clk);
		#1 chk("frozen cfg", 128'(expect_cfg(80'h23, g)), 128'(tx_cfg));
		@(posedge sys_clk);
		clk_en <= 1'b1;
		repeat (4) @(posedge sys_clk);
		#1 chk("resumed cfg", 128'(expect_cfg(80'h6, g)), 128'(tx_cfg));
		axi(1'b0, 6'h10);
		chk("unmapped read", 128'(r), 128'(2'h2));
		axi(1'b1, 6'h0C);
		chk("read-only write", 128'(r), 128'(2'h2));
		wrap_up();
	end
endmodule
`default_nettype wire
